// file: logic/burst_counter.sv
// two-bit wraparound burst counter with linear or interleaved order
`timescale 1ns/1ps
module burst_counter (
	input wire logic i_clk,
	input wire logic i_rst_n,
	burst_if.cnt bus
);
	logic [1:0] start_reg;
	logic [1:0] step_reg;
	wire [1:0] step_plus = 2'(step_reg + sram_port_pkg::BURST_STEP);

	// xor against the step for interleaved, modulo-four add for linear
	assign bus.cur = bus.interleaved ? (start_reg ^ step_reg) : 2'(start_reg + step_reg); // see R4
	assign bus.ahead = bus.interleaved ? (start_reg ^ step_plus) : 2'(start_reg + step_plus); // see R4

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_reg <= sram_port_pkg::BURST_FIRST;
			step_reg <= sram_port_pkg::BURST_FIRST;
		end else if (bus.load) begin
			start_reg <= bus.load_val; // see R5
			step_reg <= sram_port_pkg::BURST_FIRST;
		end else if (bus.advance) begin
			step_reg <= step_plus; // see R5
		end
	end

	a_load_first_addr: assert property ( // see R5
		@(posedge i_clk) disable iff (!i_rst_n)
		bus.load |=> bus.cur == $past(bus.load_val)
	) else $error("burst counter did not load the first address");

	a_interleave_second: assert property ( // see R4
		@(posedge i_clk) disable iff (!i_rst_n)
		(!bus.load && bus.advance && bus.interleaved && step_reg == 2'h0)
		|=> bus.cur == ($past(bus.cur) ^ 2'h1)
	) else $error("interleaved second address wrong");
endmodule

// file: logic/burst_if.sv
// carries the burst counter controls and its address outputs
`timescale 1ns/1ps
interface burst_if;
	logic load;
	logic [1:0] load_val;
	logic advance;
	logic interleaved;
	logic [1:0] cur;
	logic [1:0] ahead;

	modport ctrl (output load, load_val, advance, interleaved, input cur, ahead);
	modport cnt (input load, load_val, advance, interleaved, output cur, ahead);
endinterface

// file: logic/flow_through_burst_sram_port.sv
// flow-through burst sram with byte writes, chip selects and a test port
// Summary of operation
// R1 - every synchronous input is taken on the rising clock edge
// R2 - burst order, interleaved or linear, follows the sampled mode input
// R3 - mode low gives linear; high or floating gives interleaved; kept static
// R4 - linear adds one modulo four; interleaved xors start with step count
// R5 - two-bit wrapping counter loads first address, makes the rest
// R6 - the burst address steps only when advance is asserted
// R7 - internal address is upper registered bits plus the counter value
// R8 - byte write enable with per-byte selects writes only selected bytes
// R9 - global write overrides byte controls and writes all four bytes
// R10 - writes are self-timed; the host gives no write pulse
// R11 - three registered chip selects must all be active to select
// R12 - output enable is asynchronous; deasserted means data and parity float
// R13 - processor strobe is ignored while the first chip select is high
// R14 - with both strobes asserted only the processor strobe counts
// R15 - controller strobe loads the address and its low bits into the counter
// R16 - test port drives its serial output on the test clock fall
// R17 - test port samples serial input and mode select on test clock rise
`timescale 1ns/1ps
module flow_through_burst_sram_port #(
	parameter int ADDR_BITS = sram_port_pkg::ADDR_BITS,
	parameter int DATA_BYTES = sram_port_pkg::DATA_BYTES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [ADDR_BITS-1:0] i_addr,
	input wire logic [DATA_BYTES*sram_port_pkg::BYTE_BITS-1:0] i_data,
	output logic [DATA_BYTES*sram_port_pkg::BYTE_BITS-1:0] o_data,
	output logic o_data_oe,
	input wire logic [DATA_BYTES-1:0] i_parity_io,
	output logic [DATA_BYTES-1:0] o_parity_io,
	output logic o_parity_oe,
	input wire logic i_chip_sel_a_n,
	input wire logic i_chip_sel_b,
	input wire logic i_chip_sel_c_n,
	input wire logic i_proc_addr_strobe_n,
	input wire logic i_ctrl_addr_strobe_n,
	input wire logic i_burst_advance_n,
	input wire logic i_byte_wr_en_n,
	input wire logic [DATA_BYTES-1:0] i_byte_wr_sel_n,
	input wire logic i_global_wr_n,
	input wire logic i_out_en_n,
	input wire logic i_burst_mode,
	input wire logic i_scan_clk,
	input wire logic i_scan_in,
	input wire logic i_scan_mode_sel,
	output logic o_scan_out,
	output logic o_scan_mode
);
	localparam int BB = sram_port_pkg::BYTE_BITS;
	localparam int LB = sram_port_pkg::LOW_ADDR_BITS;
	localparam int DEPTH = 1 << ADDR_BITS;

	sram_port_pkg::access_state_t state_reg;
	sram_port_pkg::access_state_t state_next;
	logic [ADDR_BITS-1:LB] addr_reg;
	logic mode_reg;
	logic drive_reg;

	burst_if bcnt ();

	// strobe qualification: processor strobe needs chip select a low
	wire proc_start = ~i_proc_addr_strobe_n & ~i_chip_sel_a_n; // see R13
	wire ctrl_start = ~i_ctrl_addr_strobe_n & ~proc_start; // see R14
	wire any_start = proc_start | ctrl_start;
	wire selected = ~i_chip_sel_a_n & i_chip_sel_b & ~i_chip_sel_c_n; // see R11
	wire begin_access = any_start & selected;
	wire in_burst = (state_reg == sram_port_pkg::ST_BURST);
	wire cont = ~any_start & in_burst;
	wire step_now = cont & ~i_burst_advance_n; // see R6

	// address used this cycle; an advancing cycle already uses the next slot
	wire [LB-1:0] low_addr = any_start ? i_addr[LB-1:0] : (step_now ? bcnt.ahead : bcnt.cur);
	wire [ADDR_BITS-LB-1:0] high_addr = any_start ? i_addr[ADDR_BITS-1:LB] : addr_reg;
	wire [ADDR_BITS-1:0] eff_addr = {high_addr, low_addr}; // see R7

	// write qualification; a processor-started first cycle ignores writes
	wire [DATA_BYTES-1:0] byte_mask = i_byte_wr_en_n ? '0 : ~i_byte_wr_sel_n; // see R8
	wire [DATA_BYTES-1:0] req_mask = i_global_wr_n ? byte_mask : '1; // see R9
	wire write_ok = (begin_access & ~proc_start) | cont;
	wire [DATA_BYTES-1:0] wr_mask = write_ok ? req_mask : '0;
	wire write_any = |wr_mask;
	wire read_now = (begin_access | cont) & ~write_any;

	assign state_next = any_start
		? (selected ? sram_port_pkg::ST_BURST : sram_port_pkg::ST_IDLE)
		: state_reg;

	assign bcnt.load = begin_access; // see R15
	assign bcnt.load_val = i_addr[LB-1:0]; // see R15
	assign bcnt.advance = step_now; // see R6
	assign bcnt.interleaved = (mode_reg == sram_port_pkg::MODE_INTERLEAVED); // see R2

	burst_counter u_burst_counter (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.bus(bcnt)
	);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= sram_port_pkg::ST_IDLE;
			addr_reg <= '0;
			mode_reg <= sram_port_pkg::MODE_RESET;
			drive_reg <= 1'b0;
		end else begin
			state_reg <= state_next; // see R1
			mode_reg <= i_burst_mode; // see R3
			drive_reg <= read_now;
			if (begin_access) begin
				addr_reg <= i_addr[ADDR_BITS-1:LB]; // see R15
			end
		end
	end

	// one array per lane so each byte has a single writer; the write lands
	// on the clock edge itself, no separate strobe is needed
	generate
		for (genvar b = 0; b < DATA_BYTES; b++) begin : g_lane
			logic [BB-1:0] data_mem [DEPTH];
			logic par_mem [DEPTH];
			logic [BB-1:0] rd_data_reg;
			logic rd_par_reg;

			always_ff @(posedge i_clk) begin
				if (wr_mask[b]) begin
					data_mem[eff_addr] <= i_data[b*BB +: BB]; // see R10
					par_mem[eff_addr] <= i_parity_io[b]; // see R8
				end
			end

			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					rd_data_reg <= '0;
					rd_par_reg <= 1'b0;
				end else if (read_now) begin
					rd_data_reg <= data_mem[eff_addr];
					rd_par_reg <= par_mem[eff_addr];
				end
			end

			assign o_data[b*BB +: BB] = rd_data_reg;
			assign o_parity_io[b] = rd_par_reg;
		end
	endgenerate

	// the enable is gated without a clock so the bus releases at once
	assign o_data_oe = drive_reg & ~i_out_en_n; // see R12
	assign o_parity_oe = drive_reg & ~i_out_en_n; // see R12

	scan_port u_scan_port (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_scan_clk(i_scan_clk),
		.i_scan_in(i_scan_in),
		.i_scan_mode_sel(i_scan_mode_sel),
		.o_scan_out(o_scan_out),
		.o_scan_mode(o_scan_mode)
	);

	a_ctrl_load_addr: assert property ( // see R15
		@(posedge i_clk) disable iff (!i_rst_n)
		(ctrl_start && selected)
		|=> (addr_reg == $past(i_addr[ADDR_BITS-1:LB])) && (bcnt.cur == $past(i_addr[LB-1:0]))
	) else $error("controller strobe did not load the address");

	a_proc_ignored: assert property ( // see R13
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_chip_sel_a_n && !i_proc_addr_strobe_n && i_ctrl_addr_strobe_n)
		|=> $stable(addr_reg) && (state_reg == $past(state_reg))
	) else $error("processor strobe acted with chip select a high");

	a_proc_priority: assert property ( // see R14
		@(posedge i_clk) disable iff (!i_rst_n)
		(!i_proc_addr_strobe_n && !i_ctrl_addr_strobe_n && selected && !i_global_wr_n)
		|=> drive_reg
	) else $error("controller strobe was honoured over processor strobe");

	a_deselect_cycle: assert property ( // see R11
		@(posedge i_clk) disable iff (!i_rst_n)
		(any_start && (!i_chip_sel_b || i_chip_sel_c_n))
		|=> (state_reg == sram_port_pkg::ST_IDLE) && !drive_reg
	) else $error("access started while a chip select was inactive");

	a_hold_no_adv: assert property ( // see R6
		@(posedge i_clk) disable iff (!i_rst_n)
		(cont && i_burst_advance_n) |=> (bcnt.cur == $past(bcnt.cur))
	) else $error("burst address moved without advance");

	a_linear_step: assert property ( // see R4
		@(posedge i_clk) disable iff (!i_rst_n)
		(step_now && mode_reg == sram_port_pkg::MODE_LINEAR && i_burst_mode == sram_port_pkg::MODE_LINEAR)
		|=> bcnt.cur == 2'($past(bcnt.cur) + 2'h1)
	) else $error("linear burst did not add one");

	a_upper_stable: assert property ( // see R7
		@(posedge i_clk) disable iff (!i_rst_n)
		begin_access ##1 (!any_start)[*3]
		|-> eff_addr[ADDR_BITS-1:LB] == $past(i_addr[ADDR_BITS-1:LB], 3)
	) else $error("upper address changed inside a burst");

	a_global_all: assert property ( // see R9
		@(posedge i_clk) disable iff (!i_rst_n)
		(cont && !i_global_wr_n) ##1 (read_now && eff_addr == $past(eff_addr))
		|=> (o_data == $past(i_data, 2)) && (o_parity_io == $past(i_parity_io, 2))
	) else $error("global write did not store all bytes");

	a_byte_lane: assert property ( // see R8
		@(posedge i_clk) disable iff (!i_rst_n)
		(cont && i_global_wr_n && !i_byte_wr_en_n && i_byte_wr_sel_n[0] == 1'b0)
		##1 (read_now && eff_addr == $past(eff_addr))
		|=> o_data[BB-1:0] == $past(i_data[BB-1:0], 2)
	) else $error("selected byte was not written");

	a_write_float: assert property ( // see R10
		@(posedge i_clk) disable iff (!i_rst_n)
		write_any |=> !o_data_oe && !o_parity_oe
	) else $error("data driven after a write cycle");

	a_oe_release: assert property ( // see R12
		@(posedge i_clk) disable iff (!i_rst_n)
		i_out_en_n |-> !o_data_oe && !o_parity_oe
	) else $error("data driven with output enable deasserted");

	c_full_burst: cover property (
		@(posedge i_clk) disable iff (!i_rst_n)
		begin_access ##1 step_now[*3]
	);

	c_ctrl_write: cover property (
		@(posedge i_clk) disable iff (!i_rst_n)
		ctrl_start && selected && write_any
	);

	c_proc_read: cover property (
		@(posedge i_clk) disable iff (!i_rst_n)
		proc_start && selected ##1 o_data_oe
	);
endmodule

// file: logic/scan_port.sv
// serial test port: samples on test clock rise, drives out on its fall
`timescale 1ns/1ps
module scan_port (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_scan_clk,
	input wire logic i_scan_in,
	input wire logic i_scan_mode_sel,
	output logic o_scan_out,
	output logic o_scan_mode
);
	logic tck_reg;
	logic cap_reg;
	logic mode_reg;
	logic out_reg;
	// test clock is slow against i_clk, so its edges are found by sampling
	wire tck_rise = i_scan_clk & ~tck_reg;
	wire tck_fall = ~i_scan_clk & tck_reg;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tck_reg <= 1'b0;
			cap_reg <= 1'b0;
			mode_reg <= 1'b0;
			out_reg <= sram_port_pkg::SCAN_OUT_RESET;
		end else begin
			tck_reg <= i_scan_clk;
			if (tck_rise) begin
				cap_reg <= i_scan_in; // see R17
				mode_reg <= i_scan_mode_sel; // see R17
			end
			if (tck_fall) begin
				out_reg <= cap_reg; // see R16
			end
		end
	end

	assign o_scan_out = out_reg;
	assign o_scan_mode = mode_reg;

	a_scan_sample_rise: assert property ( // see R17
		@(posedge i_clk) disable iff (!i_rst_n)
		tck_rise |=> (cap_reg == $past(i_scan_in)) && (mode_reg == $past(i_scan_mode_sel))
	) else $error("scan input not sampled on test clock rise");

	a_scan_drive_fall: assert property ( // see R16
		@(posedge i_clk) disable iff (!i_rst_n)
		!tck_fall |=> $stable(o_scan_out)
	) else $error("scan output changed away from test clock fall");
endmodule

// file: logic/sram_port_pkg.sv
// shared constants and types for the flow-through burst sram port
package sram_port_pkg;
	localparam int DATA_BYTES = 4;
	localparam int BYTE_BITS = 8;
	localparam int ADDR_BITS = 18;
	localparam int BURST_BITS = 2;
	localparam int LOW_ADDR_BITS = 2;
	localparam int CLK_PERIOD_NS = 20;
	localparam logic [1:0] BURST_STEP = 2'h1;
	localparam logic [1:0] BURST_FIRST = 2'h0;
	localparam logic MODE_LINEAR = 1'b0;
	localparam logic MODE_INTERLEAVED = 1'b1;
	// a floating strap pin pulls up, so reset assumes interleaved
	localparam logic MODE_RESET = MODE_INTERLEAVED;
	localparam logic SCAN_OUT_RESET = 1'b0;

	typedef enum logic {ST_IDLE, ST_BURST} access_state_t;
endpackage

// file: testbench/flow_through_burst_sram_port_tb_top.sv
// self-checking bench for the flow-through burst sram port
`timescale 1ns/1ps
module flow_through_burst_sram_port_tb_top;
	typedef struct {logic [4:0] ctl; logic [3:0] bsel_n; logic [17:0] a; logic [31:0] d;
		logic [31:0] exp; logic oe;} row_t;
	localparam logic [2:0] SEL_ON = 3'h2;
	localparam logic [4:0] BURST_ADVANCE_N = 5'h1B;
	localparam logic [4:0] HOLD = 5'h1F;
	localparam logic [4:0] RD_C = 5'h17;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic out_en_n = 1'b0;
	logic burst_mode = 1'b1;
	logic scan_clk = 1'b0;
	logic scan_in = 1'b0;
	logic scan_mode_sel = 1'b0;
	logic [17:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [3:0] par_in;
	logic [3:0] par_out;
	// parity after the table's writes, by low address bits
	logic [3:0] par_exp [4] = '{4'h1, 4'h7, 4'h3, 4'h8};
	logic sel_a_n, sel_b, sel_c_n, ps_n, cs_n, adv_n, gw_n, be_n;
	logic [3:0] bsel_n;
	logic data_oe, parity_oe, scan_out, scan_mode;
	int num_errors = 0;
	int n_tests = 0;
	// contents after the table's writes, by low address bits
	logic [31:0] word [4] = '{32'h11111111, 32'h22BB22DD, 32'h33333333, 32'h55667788};
	row_t rows [9] = '{
		'{5'h15, 4'hF, 18'h00100, 32'h11111111, 32'h00000000, 1'b0},
		'{5'h15, 4'hF, 18'h00101, 32'h22222222, 32'h00000000, 1'b0},
		'{5'h15, 4'hF, 18'h00102, 32'h33333333, 32'h00000000, 1'b0},
		'{5'h15, 4'hF, 18'h00103, 32'h44444444, 32'h00000000, 1'b0},
		'{5'h16, 4'hA, 18'h00101, 32'hAABBCCDD, 32'h00000000, 1'b0},
		'{5'h14, 4'hF, 18'h00103, 32'h55667788, 32'h00000000, 1'b0},
		'{RD_C, 4'hF, 18'h00101, 32'h00000000, 32'h22BB22DD, 1'b1},
		'{RD_C, 4'hF, 18'h00103, 32'h00000000, 32'h55667788, 1'b1},
		'{RD_C, 4'hF, 18'h00100, 32'h00000000, 32'h11111111, 1'b1}};

	always #10 clk = ~clk;

	host_model host_model_i (.i_clk(clk), .o_addr(addr), .o_data(wdata), .o_parity(par_in),
		.o_sel_a_n(sel_a_n), .o_sel_b(sel_b), .o_sel_c_n(sel_c_n), .o_ps_n(ps_n),
		.o_cs_n(cs_n), .o_adv_n(adv_n), .o_gw_n(gw_n), .o_be_n(be_n), .o_bsel_n(bsel_n));

	flow_through_burst_sram_port flow_through_burst_sram_port_i (.i_clk(clk), .i_rst_n(rst_n),
		.i_addr(addr), .i_data(wdata), .o_data(rdata), .o_data_oe(data_oe),
		.i_parity_io(par_in), .o_parity_io(par_out), .o_parity_oe(parity_oe),
		.i_chip_sel_a_n(sel_a_n), .i_chip_sel_b(sel_b), .i_chip_sel_c_n(sel_c_n),
		.i_proc_addr_strobe_n(ps_n), .i_ctrl_addr_strobe_n(cs_n), .i_burst_advance_n(adv_n),
		.i_byte_wr_en_n(be_n), .i_byte_wr_sel_n(bsel_n), .i_global_wr_n(gw_n),
		.i_out_en_n(out_en_n), .i_burst_mode(burst_mode), .i_scan_clk(scan_clk),
		.i_scan_in(scan_in), .i_scan_mode_sel(scan_mode_sel), .o_scan_out(scan_out),
		.o_scan_mode(scan_mode));

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (exp !== got) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task test_done;
		$display("comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// deselect by dropping the high-active select with the controller strobe
	task idle;
		host_model_i.cyc(3'h0, RD_C, 4'hF, 18'h00000, 32'h00000000);
	endtask

	// burst from base 0x100; advance pattern walks interleaved or linear order
	task burst(input logic [4:0] start, input logic [1:0] lo, input logic inter);
		logic [1:0] k;
		k = 2'h0;
		host_model_i.cyc(SEL_ON, start, 4'hF, {16'h0040, lo}, 32'h00000000);
		chk("burst first", word[lo], rdata);
		for (int i = 0; i < 5; i++) begin
			// the address pins carry junk: upper bits must come from the register
			host_model_i.cyc(SEL_ON, (i == 3) ? HOLD : BURST_ADVANCE_N, 4'hF, 18'h3FFFF, 32'h00000000);
			k = (i == 3) ? k : k + 2'h1;
			chk("burst step", word[inter ? (lo ^ k) : (lo + k)], rdata);
		end
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		$display("unexpected timeout: expected completion, seen none");
		test_done;
	end

	initial begin
		repeat (11) @(negedge clk);
		chk("reset oe", 32'h0, 32'(data_oe));
		chk("reset data", 32'h0, rdata);
		chk("reset scan", 32'h0, 32'(scan_out));
		@(negedge clk);
		rst_n = 1'b1;
		foreach (rows[r]) begin
			host_model_i.cyc(SEL_ON, rows[r].ctl, rows[r].bsel_n, rows[r].a, rows[r].d);
			chk("row oe", 32'(rows[r].oe), 32'(data_oe));
			if (rows[r].oe) chk("row data", rows[r].exp, rdata);
			if (rows[r].oe) chk("row parity", 32'(par_exp[rows[r].a[1:0]]), 32'(par_out));
		end
		$display("test table done");
		burst(5'h0F, 2'h2, 1'b1);
		out_en_n = 1'b1;
		#1;
		chk("oe off", 32'h0, {30'h0, data_oe, parity_oe});
		out_en_n = 1'b0;
		#1;
		chk("oe on", 32'h3, {30'h0, data_oe, parity_oe});
		$display("test interleaved done");
		idle();
		@(negedge clk);
		burst_mode = 1'b0;
		idle();
		burst(RD_C, 2'h1, 1'b0);
		$display("test linear done");
		for (int i = 0; i < 3; i++) begin
			host_model_i.cyc(SEL_ON, RD_C, 4'hF, 18'h00100, 32'h00000000);
			host_model_i.cyc(SEL_ON ^ (3'h1 << i), RD_C, 4'hF, 18'h00100, 32'h00000000);
			chk("partial select", 32'h0, 32'(data_oe));
		end
		host_model_i.cyc(3'h6, 5'h0F, 4'hF, 18'h00102, 32'h00000000);
		chk("proc strobe ignored", 32'h0, 32'(data_oe));
		host_model_i.cyc(SEL_ON, 5'h05, 4'hF, 18'h00103, 32'hDEADBEEF);
		chk("both strobes", word[3], rdata);
		host_model_i.cyc(SEL_ON, RD_C, 4'hF, 18'h00103, 32'h00000000);
		chk("no write", word[3], rdata);
		// writes inside a burst, each read back at the held address
		host_model_i.cyc(SEL_ON, 5'h1D, 4'hF, 18'h3FFFF, 32'hCAFEF00D);
		host_model_i.cyc(SEL_ON, HOLD, 4'hF, 18'h3FFFF, 32'h00000000);
		chk("burst global write", 32'hCAFEF00D, rdata);
		chk("burst global parity", 32'hD, 32'(par_out));
		host_model_i.cyc(SEL_ON, 5'h1E, 4'hE, 18'h3FFFF, 32'h000000A5);
		host_model_i.cyc(SEL_ON, HOLD, 4'hF, 18'h3FFFF, 32'h00000000);
		chk("burst byte write", 32'hCAFEF0A5, rdata);
		$display("test selects done");
		@(negedge clk);
		scan_in = 1'b1;
		scan_mode_sel = 1'b1;
		repeat (4) @(negedge clk);
		scan_clk = 1'b1;
		repeat (4) @(negedge clk);
		scan_in = 1'b0;
		scan_mode_sel = 1'b0;
		chk("scan out at rise", 32'h0, 32'(scan_out));
		chk("scan mode", 32'h1, 32'(scan_mode));
		scan_clk = 1'b0;
		repeat (4) @(negedge clk);
		chk("scan out at fall", 32'h1, 32'(scan_out));
		$display("test scan done");
		test_done;
	end
endmodule

// file: testbench/host_model.sv
// host model: drives the sram port's synchronous inputs, one bus cycle per call
`timescale 1ns/1ps
module host_model (
	input wire logic i_clk,
	output logic [17:0] o_addr,
	output logic [31:0] o_data,
	output logic [3:0] o_parity,
	output logic o_sel_a_n,
	output logic o_sel_b,
	output logic o_sel_c_n,
	output logic o_ps_n,
	output logic o_cs_n,
	output logic o_adv_n,
	output logic o_gw_n,
	output logic o_be_n,
	output logic [3:0] o_bsel_n
);
	initial begin
		{o_sel_a_n, o_sel_b, o_sel_c_n, o_ps_n, o_cs_n, o_adv_n, o_gw_n, o_be_n} = 8'hDF;
		o_bsel_n = 4'hF;
		o_addr = 18'h00000;
		o_data = 32'h00000000;
		o_parity = 4'h0;
	end
	// ctl is {proc strobe, ctrl strobe, advance, global write, byte write enable}, all low active
	task cyc(input logic [2:0] sel, input logic [4:0] ctl, input logic [3:0] bsel_n,
		input logic [17:0] a, input logic [31:0] d);
		@(negedge i_clk);
		{o_sel_a_n, o_sel_b, o_sel_c_n} = sel;
		{o_ps_n, o_cs_n, o_adv_n, o_gw_n, o_be_n} = ctl;
		o_bsel_n = bsel_n;
		o_addr = a;
		// levels only, no write pulse; a released bus shows a changing pattern, not old data
		o_data = (!ctl[1] || !ctl[0]) ? d : ~o_data;
		o_parity = (!ctl[1] || !ctl[0]) ? d[3:0] : ~o_parity;
		@(posedge i_clk);
		#5;
	endtask
endmodule
